// ---- dv/tb_top.sv ----
// self-checking bench for the branch and increment executor
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk;
   logic        rst_b;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        busy;
   logic [20:0] exp_pc;
   int          err_count;
   int          n_compared;

   bie_core dut_u (
      .CLK_IN    (clk),
      .RST_B_IN  (rst_b),
      .WB_CYC_IN (wb_cyc),
      .WB_STB_IN (wb_stb),
      .WB_WE_IN  (wb_we),
      .WB_ADR_IN (wb_adr),
      .WB_SEL_IN (wb_sel),
      .WB_DAT_IN (wb_dat),
      .WB_DAT_OUT(wb_rdat),
      .WB_ACK_OUT(wb_ack),
      .BUSY_OUT  (busy)
   );

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // waits for ack with no assumed latency; only the watchdog ends a lost cycle
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_sel <= 4'hf;
      wb_dat <= wd;
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      check("ack", {31'h0, wb_ack}, 32'h1);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] rd;
      wb_xfer(1'b1, adr, wd, rd);
   endtask

   task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 32'h0, rd);
      check(name, rd, exp);
   endtask

   // counts busy cycles, the ack edge of the starting write included
   task automatic wait_idle(output int n);
      n = 1;
      @(posedge clk);
      while (busy === 1'b1 && n < 100) begin
         n++;
         @(posedge clk);
      end
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      exp_pc = 21'h0;
   endtask

   // status is preset to the inverse so a flag that never updates shows
   task automatic do_inc_file(input logic [15:0] ins, input logic [11:0] fa,
                          input logic [7:0] init, input logic [7:0] res, input logic [4:0] st);
      int n;
      wr(bie_pkg::OFS_FADDR, {20'h0, fa});
      wr(bie_pkg::OFS_FDATA, {24'h0, init});
      wr(bie_pkg::OFS_WREG, 32'h5a);
      wr(bie_pkg::OFS_STATUS, {27'h0, ~st});
      wr(bie_pkg::OFS_INSTR, {16'h0, ins});
      wait_idle(n);
      exp_pc = exp_pc + 21'h2;
      check("inc cycles", 32'(n), 32'h4);
      rdchk("file", bie_pkg::OFS_FDATA, {24'h0, ins[9] ? res : init});
      rdchk("wreg", bie_pkg::OFS_WREG, {24'h0, ins[9] ? 8'h5a : res});
      rdchk("status", bie_pkg::OFS_STATUS, {27'h0, st});
      rdchk("pc", bie_pkg::OFS_PC, {11'h0, exp_pc});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // an opcode that is neither branch nor increment runs one idle cycle and steps pc
   task automatic t_reset_values();
      int n;
      rdchk("pc", bie_pkg::OFS_PC, 32'h0);
      rdchk("wreg", bie_pkg::OFS_WREG, 32'h0);
      rdchk("status", bie_pkg::OFS_STATUS, 32'h0);
      rdchk("unmapped", 8'h3c, 32'h0);
      wr(bie_pkg::OFS_PC, 32'h1234);
      rdchk("pc", bie_pkg::OFS_PC, 32'h0);
      wr(bie_pkg::OFS_INSTR, 32'h0);
      wait_idle(n);
      check("no-op cycles", 32'(n), 32'h4);
      exp_pc = 21'h2;
      rdchk("pc after no-op", bie_pkg::OFS_PC, 32'h2);
   endtask

   task automatic t_inc_banks();
      wr(bie_pkg::OFS_BANK, 32'h3);
      do_inc_file(16'h2b45, 12'h345, 8'h7f, 8'h80, 5'h1a);
      do_inc_file(16'h2870, 12'hf70, 8'hff, 8'h00, 5'h07);
      do_inc_file(16'h2a10, 12'h010, 8'h3a, 8'h3b, 5'h00);
   endtask

   task automatic t_inc_indexed();
      wr(bie_pkg::OFS_CTRL, 32'h1);
      wr(bie_pkg::OFS_INDEX, 32'h200);
      do_inc_file(16'h2a5f, 12'h25f, 8'h05, 8'h06, 5'h00);
      do_inc_file(16'h2a60, 12'hf60, 8'h8f, 8'h90, 5'h12);
      do_inc_file(16'h2b20, 12'h320, 8'h0f, 8'h10, 5'h02);
      wr(bie_pkg::OFS_CTRL, 32'h0);
   endtask

   task automatic t_branch_max();
      int n;
      wr(bie_pkg::OFS_STATUS, 32'h0a);
      wr(bie_pkg::OFS_INSTR, {4'hf, 12'hfff, bie_pkg::OPC_BRANCH, 8'hff});
      wait_idle(n);
      check("branch cycles", 32'(n), 32'h8);
      exp_pc = {bie_pkg::BR_K_MAX, 1'b0};
      rdchk("pc", bie_pkg::OFS_PC, {11'h0, exp_pc});
      rdchk("status", bie_pkg::OFS_STATUS, 32'h0a);
   endtask

   task automatic t_branch_busy();
      int n;
      wr(bie_pkg::OFS_WREG, 32'h5a);
      wr(bie_pkg::OFS_STATUS, 32'h15);
      wr(bie_pkg::OFS_INSTR, {4'hf, 12'h123, bie_pkg::OPC_BRANCH, 8'h45});
      wr(bie_pkg::OFS_WREG, 32'h77);
      rdchk("status busy", bie_pkg::OFS_STATUS, 32'h115);
      wait_idle(n);
      rdchk("wreg", bie_pkg::OFS_WREG, 32'h5a);
      rdchk("status", bie_pkg::OFS_STATUS, 32'h15);
      rdchk("pc", bie_pkg::OFS_PC, 32'h2468a);
   endtask

   // second reset in mid-run must clear the state left by earlier work
   task automatic t_reset_again();
      do_reset();
      rdchk("pc", bie_pkg::OFS_PC, 32'h0);
      rdchk("wreg", bie_pkg::OFS_WREG, 32'h0);
      rdchk("status", bie_pkg::OFS_STATUS, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      err_count = 0;
      n_compared = 0;
      exp_pc = 21'h0;
      rst_b = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hf;
      wb_dat = 32'h0;
      @(posedge clk);
      do_reset();
      t_reset_values();
      t_inc_banks();
      t_inc_indexed();
      t_branch_max();
      t_branch_busy();
      t_reset_again();
      end_sim();
   end

   // the whole sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("unexpected watchdog: expected done seen timeout");
      end_sim();
   end
endmodule

// ---- hdl/bie_core.sv ----
// branch and increment executor with wishbone register access
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module bie_core #(
   parameter int AW = 12
) (
   input  wire logic        CLK_IN,
   input  wire logic        RST_B_IN,
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [7:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output logic      [31:0] WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   output logic             BUSY_OUT
);
   // -----------------------------------------------------------------------
   // parameter check
   // -----------------------------------------------------------------------
   generate
      if (AW != 12) begin : g_bad_aw
         $error("bie_core: file address width must be 12");
      end
   endgenerate

   // -----------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------
   bie_pkg::bie_state_t st_q, st_d;
   logic        cyc2_q, cyc2_d;
   logic [31:0] ir_q, ir_d;
   logic [7:0]  klo_q, klo_d;
   logic [7:0]  opnd_q, opnd_d;
   logic [7:0]  res_q, res_d;
   logic [20:0] pc_q, pc_d;
   logic [7:0]  w_q, w_d;
   logic [4:0]  stat_q, stat_d;
   logic        ext_q, ext_d;
   logic [3:0]  bnk_q, bnk_d;
   logic [11:0] idx_q, idx_d;
   logic [11:0] faddr_q, faddr_d;
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic        pend_q, pend_d;
   logic        busy_q, busy_d;
   logic        mem_en, mem_we;
   logic [11:0] mem_addr;
   logic [7:0]  mem_wdata, mem_rdata;
   bie_pkg::bie_dec_t dec;
   logic [11:0] ea;
   logic        req;
   logic [7:0]  adr;
   logic [31:0] wm;
   logic [31:0] idx_m, fad_m;
   assign dec = bie_pkg::bie_decode(ir_q[15:0]);
   assign ea  = bie_pkg::bie_eaddr(dec, ext_q, bnk_q, idx_q);
   assign req = WB_CYC_IN && WB_STB_IN && !ack_q;
   assign adr = {WB_ADR_IN[7:2], 2'b00};
   // merged in a variable first: a function result cannot be part-selected directly
   assign idx_m = bie_pkg::bie_merge({20'h00000, idx_q}, WB_DAT_IN, WB_SEL_IN);
   assign fad_m = bie_pkg::bie_merge({20'h00000, faddr_q}, WB_DAT_IN, WB_SEL_IN);
   bie_fmem #(.AW(AW), .DW(8)) u_fmem (
      .clk_in    (CLK_IN),
      .en_in     (mem_en),
      .we_in     (mem_we),
      .addr_in   (mem_addr),
      .wdata_in  (mem_wdata),
      .rdata_out (mem_rdata)
   );

   // -----------------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      cyc2_d    = cyc2_q;
      ir_d      = ir_q;
      klo_d     = klo_q;
      opnd_d    = opnd_q;
      res_d     = res_q;
      pc_d      = pc_q;
      w_d       = w_q;
      stat_d    = stat_q;
      ext_d     = ext_q;
      bnk_d     = bnk_q;
      idx_d     = idx_q;
      faddr_d   = faddr_q;
      ack_d     = 1'b0;
      dat_d     = dat_q;
      pend_d    = pend_q;
      mem_en    = 1'b0;
      mem_we    = 1'b0;
      mem_addr  = faddr_q;
      mem_wdata = WB_DAT_IN[7:0];
      wm        = bie_pkg::bie_merge(32'h00000000, WB_DAT_IN, WB_SEL_IN);
      // sequencer: one instruction cycle is four q phases of one clock each
      unique case (st_q)
         bie_pkg::ST_IDLE: begin
            cyc2_d = 1'b0;
         end
         bie_pkg::ST_Q1: begin
            st_d = bie_pkg::ST_Q2;
            if (!cyc2_q && dec.is_inc) begin
               mem_en   = 1'b1;
               mem_addr = ea;
            end
         end
         bie_pkg::ST_Q2: begin
            st_d = bie_pkg::ST_Q3;
            if (!cyc2_q && dec.is_br) begin
               klo_d = ir_q[7:0];
            end
            if (!cyc2_q && dec.is_inc) begin
               opnd_d = mem_rdata;
            end
         end
         bie_pkg::ST_Q3: begin
            st_d  = bie_pkg::ST_Q4;
            res_d = opnd_q + 8'h01;
         end
         bie_pkg::ST_Q4: begin
            st_d = bie_pkg::ST_IDLE;
            if (cyc2_q) begin
               cyc2_d = 1'b0;
            end else if (dec.is_br) begin
               // second cycle is a dead cycle while fetch restarts at the target
               pc_d   = {ir_q[27:16], klo_q, 1'b0};
               cyc2_d = 1'b1;
               st_d   = bie_pkg::ST_Q1;
            end else begin
               pc_d = pc_q + 21'h000002;
               if (dec.is_inc) begin
                  if (dec.dest) begin
                     mem_en    = 1'b1;
                     mem_we    = 1'b1;
                     mem_addr  = ea;
                     mem_wdata = res_q;
                  end else begin
                     w_d = res_q;
                  end
                  stat_d[bie_pkg::ST_C_BIT]   = (opnd_q == 8'hff);
                  stat_d[bie_pkg::ST_DIG_BIT] = (opnd_q[3:0] == 4'hf);
                  stat_d[bie_pkg::ST_Z_BIT]   = (res_q == 8'h00);
                  stat_d[bie_pkg::ST_OVF_BIT] = (opnd_q == 8'h7f);
                  stat_d[bie_pkg::ST_N_BIT]   = res_q[7];
               end
            end
         end
      endcase
      // bus slave; register writes are ignored while an instruction runs, file data accesses wait for idle
      if (!req) begin
         pend_d = 1'b0;
      end else if (adr == bie_pkg::OFS_FDATA) begin
         if (st_q == bie_pkg::ST_IDLE) begin
            if (WB_WE_IN) begin
               mem_en = WB_SEL_IN[0];
               mem_we = 1'b1;
               ack_d  = 1'b1;
            end else if (!pend_q) begin
               mem_en = 1'b1;
               pend_d = 1'b1;
            end else begin
               pend_d = 1'b0;
               ack_d  = 1'b1;
               dat_d  = {24'h000000, mem_rdata};
            end
         end
      end else begin
         ack_d = 1'b1;
         dat_d = 32'h00000000;
         if (WB_WE_IN && st_q == bie_pkg::ST_IDLE) begin
            unique case (adr)
               bie_pkg::OFS_CTRL:   if (WB_SEL_IN[0]) ext_d = wm[bie_pkg::CTRL_EXT_BIT];
               bie_pkg::OFS_BANK:   if (WB_SEL_IN[0]) bnk_d = wm[3:0];
               bie_pkg::OFS_WREG:   if (WB_SEL_IN[0]) w_d = wm[7:0];
               bie_pkg::OFS_STATUS: if (WB_SEL_IN[0]) stat_d = wm[4:0];
               bie_pkg::OFS_INDEX:  idx_d = idx_m[11:0];
               bie_pkg::OFS_FADDR:  faddr_d = fad_m[11:0];
               bie_pkg::OFS_INSTR: begin
                  ir_d = bie_pkg::bie_merge(ir_q, WB_DAT_IN, WB_SEL_IN);
                  st_d = bie_pkg::ST_Q1;
               end
               default: ;
            endcase
         end else if (!WB_WE_IN) begin
            unique case (adr)
               bie_pkg::OFS_CTRL:   dat_d = {31'h00000000, ext_q};
               bie_pkg::OFS_BANK:   dat_d = {28'h0000000, bnk_q};
               bie_pkg::OFS_WREG:   dat_d = {24'h000000, w_q};
               bie_pkg::OFS_STATUS: dat_d = {23'h000000, busy_q, 3'h0, stat_q};
               bie_pkg::OFS_PC:     dat_d = {11'h000, pc_q};
               bie_pkg::OFS_INSTR:  dat_d = ir_q;
               bie_pkg::OFS_INDEX:  dat_d = {20'h00000, idx_q};
               bie_pkg::OFS_FADDR:  dat_d = {20'h00000, faddr_q};
               default:             dat_d = 32'h00000000;
            endcase
         end
      end
      busy_d = (st_d != bie_pkg::ST_IDLE);
   end

   // -----------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         st_q    <= bie_pkg::ST_IDLE;
         cyc2_q  <= 1'b0;
         ir_q    <= 32'h00000000;
         klo_q   <= 8'h00;
         opnd_q  <= 8'h00;
         res_q   <= 8'h00;
         pc_q    <= bie_pkg::PC_RST;
         w_q     <= bie_pkg::W_RST;
         stat_q  <= bie_pkg::STAT_RST;
         ext_q   <= 1'b0;
         bnk_q   <= 4'h0;
         idx_q   <= 12'h000;
         faddr_q <= 12'h000;
         ack_q   <= 1'b0;
         dat_q   <= 32'h00000000;
         pend_q  <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         cyc2_q  <= cyc2_d;
         ir_q    <= ir_d;
         klo_q   <= klo_d;
         opnd_q  <= opnd_d;
         res_q   <= res_d;
         pc_q    <= pc_d;
         w_q     <= w_d;
         stat_q  <= stat_d;
         ext_q   <= ext_d;
         bnk_q   <= bnk_d;
         idx_q   <= idx_d;
         faddr_q <= faddr_d;
         ack_q   <= ack_d;
         dat_q   <= dat_d;
         pend_q  <= pend_d;
         busy_q  <= busy_d;
      end
   end

   assign WB_ACK_OUT = ack_q;
   assign WB_DAT_OUT = dat_q;
   assign BUSY_OUT   = busy_q;

   // -----------------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   logic br_q4, inc_q4;
   assign br_q4  = (st_q == bie_pkg::ST_Q4) && !cyc2_q && dec.is_br;
   assign inc_q4 = (st_q == bie_pkg::ST_Q4) && !cyc2_q && dec.is_inc;
   AST_BR_PC: assert property (br_q4 |=> pc_q == {$past(ir_q[27:16]), $past(klo_q), 1'b0})
      else $error("branch target not loaded into pc");
   AST_BR_RANGE: assert property (br_q4 |=> pc_q[20:1] <= bie_pkg::BR_K_MAX && !pc_q[0])
      else $error("branch target odd or out of range");
   AST_BR_TWO: assert property ((st_q == bie_pkg::ST_Q1 && !cyc2_q && dec.is_br)
                                |-> busy_q [*8] ##1 !busy_q)
      else $error("branch did not take two cycles");
   AST_KLO: assert property ((st_q == bie_pkg::ST_Q2 && !cyc2_q && dec.is_br)
                             |=> klo_q == $past(ir_q[7:0]))
      else $error("low literal not read in q2");
   AST_INC_W: assert property ((inc_q4 && !dec.dest) |=> w_q == $past(res_q))
      else $error("increment result missing from working register");
   AST_INC_F: assert property ((inc_q4 && dec.dest)
                               |-> mem_we && mem_wdata == opnd_q + 8'h01)
      else $error("increment result not written to file");
   AST_BANKED: assert property ((st_q == bie_pkg::ST_Q1 && dec.is_inc && !cyc2_q && dec.bank)
                                |-> mem_addr == {bnk_q, dec.fa})
      else $error("banked address wrong");
   AST_ACCESS: assert property ((st_q == bie_pkg::ST_Q1 && dec.is_inc && !cyc2_q && !dec.bank
                                 && !(ext_q && dec.fa <= bie_pkg::IDX_LIMIT))
                                |-> mem_addr[7:0] == dec.fa
                                    && mem_addr[11:8] == (dec.fa[7:5] >= 3'h3 ? 4'hf : 4'h0))
      else $error("access bank address wrong");
   AST_INDEXED: assert property ((st_q == bie_pkg::ST_Q1 && dec.is_inc && !cyc2_q && !dec.bank
                                  && ext_q && dec.fa <= bie_pkg::IDX_LIMIT)
                                 |-> mem_addr == idx_q + {4'h0, dec.fa})
      else $error("indexed address wrong");
   // judged from the result, which stays put once the sequencer is back in idle
   AST_FLAGS: assert property (inc_q4 |=> stat_q[bie_pkg::ST_Z_BIT] == (res_q == 8'h00)
                               && stat_q[bie_pkg::ST_C_BIT] == (res_q == 8'h00)
                               && stat_q[bie_pkg::ST_DIG_BIT] == (res_q[3:0] == 4'h0)
                               && stat_q[bie_pkg::ST_OVF_BIT] == (res_q == 8'h80)
                               && stat_q[bie_pkg::ST_N_BIT] == res_q[7])
      else $error("status flags wrong after increment");
   AST_BR_KEEP: assert property ((busy_q && dec.is_br) |=> $stable(stat_q))
      else $error("branch changed status flags");
   COV_BR: cover property (br_q4 ##1 cyc2_q);
   COV_INC_W: cover property (inc_q4 && !dec.dest);
   COV_INC_F: cover property (inc_q4 && dec.dest && res_q == 8'h00);
   COV_IDX: cover property (st_q == bie_pkg::ST_Q1 && dec.is_inc && ext_q && !dec.bank);
endmodule

// ---- hdl/bie_fmem.sv ----
// file register memory with registered read data
`timescale 1ns/1ps
module bie_fmem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input  wire logic          clk_in,
   input  wire logic          en_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [DW-1:0] wdata_in,
   output logic      [DW-1:0] rdata_out
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset: contents are software state, read data valid one edge after en
   always_ff @(posedge clk_in) begin
      if (en_in) begin
         if (we_in) begin
            mem[addr_in] <= wdata_in;
         end
         rdata_out <= mem[addr_in];
      end
   end
endmodule

// ---- hdl/bie_pkg.sv ----
// constants, types and decode helpers for the branch and increment executor
// -----------------------------------------------------------------------
// Operation
// -----------------------------------------------------------------------
package bie_pkg;
   // -----------------------------------------------------------------------
   // register map, byte addresses on the bus
   // -----------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_BANK   = 8'h04;
   localparam logic [7:0] OFS_WREG   = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_PC     = 8'h10;
   localparam logic [7:0] OFS_INSTR  = 8'h14;
   localparam logic [7:0] OFS_INDEX  = 8'h18;
   localparam logic [7:0] OFS_FADDR  = 8'h1c;
   localparam logic [7:0] OFS_FDATA  = 8'h20;
   // field positions
   localparam int CTRL_EXT_BIT  = 0;
   localparam int ST_C_BIT      = 0;
   localparam int ST_DIG_BIT    = 1;
   localparam int ST_Z_BIT      = 2;
   localparam int ST_OVF_BIT    = 3;
   localparam int ST_N_BIT      = 4;
   localparam int ST_BUSY_BIT   = 8;
   // reset values
   localparam logic [20:0] PC_RST   = 21'h000000;
   localparam logic [4:0]  STAT_RST = 5'h00;
   localparam logic [7:0]  W_RST    = 8'h00;
   // encodings
   localparam logic [7:0]  OPC_BRANCH   = 8'hef;
   localparam logic [5:0]  OPC_INC_FILE = 6'h0a;
   localparam logic [7:0]  ACC_SPLIT    = 8'h60;
   localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
   localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
   localparam logic [19:0] BR_K_MAX     = 20'hfffff;
   localparam int CLK_PERIOD_NS = 50;
   localparam int Q_PER_CYCLE   = 4;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_Q1   = 5'b00010,
      ST_Q2   = 5'b00100,
      ST_Q3   = 5'b01000,
      ST_Q4   = 5'b10000
   } bie_state_t;

   typedef struct packed {
      logic       is_br;
      logic       is_inc;
      logic       dest;
      logic       bank;
      logic [7:0] fa;
   } bie_dec_t;

   function automatic bie_dec_t bie_decode(input logic [15:0] w);
      bie_dec_t r;
      r.is_br  = (w[15:8] == OPC_BRANCH);
      r.is_inc = (w[15:10] == OPC_INC_FILE);
      r.dest   = w[9];
      r.bank   = w[8];
      r.fa     = w[7:0];
      return r;
   endfunction

   // effective file address for increment_file
   function automatic logic [11:0] bie_eaddr(input bie_dec_t d, input logic ext,
                                            input logic [3:0] bnk, input logic [11:0] idx);
      logic [11:0] r;
      r = 12'h000;
      if (d.bank) begin
         r = {bnk, d.fa};
      end else if (ext && (d.fa <= IDX_LIMIT)) begin
         r = idx + {4'h0, d.fa};
      end else if (d.fa < ACC_SPLIT) begin
         r = {4'h0, d.fa};
      end else begin
         r = {ACC_HI_BANK, d.fa};
      end
      return r;
   endfunction

   function automatic logic [31:0] bie_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction
endpackage
